// file: verilog/modem_flow_pkg.sv
// Package: register map, reset values and carrier types for the modem-status block
package modem_flow_pkg;

    // ************************************************************
    // Register offsets (byte addresses on the plain register port)
    // ************************************************************
    localparam int          ADDR_W           = 3;
    localparam logic [2:0]  OFF_MODEM_CTRL   = 3'h0;
    localparam logic [2:0]  OFF_MODEM_STAT   = 3'h1;
    localparam logic [2:0]  OFF_SCRATCH      = 3'h2;
    localparam logic [2:0]  OFF_FEATURE      = 3'h3;
    localparam logic [2:0]  OFF_EVT_STATUS   = 3'h4;
    localparam logic [2:0]  OFF_EVT_MASK     = 3'h5;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_DTR      = 0;
    localparam int CTRL_RTS      = 1;
    localparam int CTRL_OUT1     = 2;
    localparam int CTRL_OUT2     = 3;
    localparam int CTRL_LOOP     = 4;
    localparam int FEAT_AUTO_RTS = 6;
    localparam int FEAT_AUTO_CTS = 7;
    localparam int EVT_MODEM     = 0;
    localparam int EVT_RX_TRIG   = 1;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
    localparam logic [7:0] RST_SCRATCH    = 8'hff;
    localparam logic [7:0] RST_FEATURE    = 8'h00;
    localparam logic [1:0] RST_EVT_MASK   = 2'h3;

    // Modem inputs, all active low, as sampled from the pins
    typedef struct packed {
        logic cdN;
        logic riN;
        logic dsrN;
        logic ctsN;
    } modem_in_t;

    // Modem outputs, all active low
    typedef struct packed {
        logic out2N;
        logic out1N;
        logic rtsN;
        logic dtrN;
    } modem_out_t;

endpackage

// file: verilog/modem_status_and_hw_flow.sv
// Modem-status register, change flags, scratch byte and automatic CTS/RTS flow control
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module modem_status_and_hw_flow
    import modem_flow_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdData,
    input  wire modem_in_t         modemIn,
    output modem_out_t             modemOut,
    input  wire logic [CNT_W-1:0]  rxFillCount,
    input  wire logic [CNT_W-1:0]  rxTrigLevel,
    input  wire logic [CNT_W-1:0]  rxNextLevel,
    output logic                   txHalt,
    output logic                   irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] modemCtrl;
        logic [7:0] scratch;
        logic [7:0] feature;
        logic [3:0] changeFlags;
        logic [3:0] prevUpper;
        logic       primed;
        logic       rtsHeld;
        logic       rxAtTrig;
        logic       txHalt;
        logic [1:0] evtStatus;
        logic [1:0] evtMask;
        logic [7:0] rdData;
        modem_out_t pins;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Sticky flag update: a new event wins over a clear in the same cycle
    function automatic logic [3:0] stickyUpdate(input logic [3:0] cur,
                                                input logic [3:0] set,
                                                input logic [3:0] clr);
        stickyUpdate = (cur & ~clr) | set;
    endfunction

    // ************************************************************
    // Combinational views
    // ************************************************************
    logic [3:0] upperNow;
    logic [3:0] changeSet;
    logic [7:0] statusView;
    logic [7:0] featureView;
    logic       loopMode;
    logic       rdStatus;
    logic       wrHit;
    logic       trigEdge;
    logic       anyNewFlag;
    logic [CNT_W-1:0] lowerLevel;

    assign loopMode = state_reg.modemCtrl[CTRL_LOOP];

    // Upper status nibble: loop-back source or inverted pins
    always_comb begin
        if (loopMode) begin
            upperNow = {state_reg.modemCtrl[CTRL_OUT2],
                        state_reg.modemCtrl[CTRL_OUT1],
                        state_reg.modemCtrl[CTRL_DTR],
                        state_reg.modemCtrl[CTRL_RTS]};
        end else begin
            upperNow = ~{modemIn.cdN, modemIn.riN, modemIn.dsrN, modemIn.ctsN};
        end
    end

    // Change detection; the first cycle after reset only primes the history
    always_comb begin
        changeSet = 4'h0;
        if (state_reg.primed) begin
            changeSet[3] = upperNow[3] ^ state_reg.prevUpper[3];
            changeSet[1] = upperNow[1] ^ state_reg.prevUpper[1];
            changeSet[0] = upperNow[0] ^ state_reg.prevUpper[0];
            // Ring pin rising means the status bit falls
            changeSet[2] = state_reg.prevUpper[2] & ~upperNow[2];
        end
    end

    assign statusView  = {upperNow, state_reg.changeFlags};
    // Auto RTS bit reads zero while hardware has RTS raised
    assign featureView = {state_reg.feature[7],
                          state_reg.feature[FEAT_AUTO_RTS] & ~state_reg.rtsHeld,
                          state_reg.feature[5:0]};
    assign rdStatus    = regRd && (regAddr == OFF_MODEM_STAT);
    assign wrHit       = regWr;
    assign anyNewFlag  = |(changeSet & ~state_reg.changeFlags);
    assign lowerLevel  = (rxTrigLevel == '0) ? '0 : rxTrigLevel - CNT_W'(1);
    assign trigEdge    = (rxFillCount >= rxTrigLevel) && !state_reg.rxAtTrig;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        state_next           = state_reg;
        state_next.primed    = 1'b1;
        state_next.prevUpper = upperNow;
        state_next.rdData    = 8'h00;

        // Register writes
        if (wrHit) begin
            unique case (regAddr)
                OFF_MODEM_CTRL: state_next.modemCtrl = regWrData;
                OFF_SCRATCH:    state_next.scratch   = regWrData;
                OFF_FEATURE:    state_next.feature   = regWrData;
                OFF_EVT_MASK:   state_next.evtMask   = regWrData[1:0];
                default: ;
            endcase
        end

        // Change flags: read clears, new change keeps its flag
        state_next.changeFlags = stickyUpdate(state_reg.changeFlags, changeSet,
                                              {4{rdStatus}});

        // Receive trigger tracking for the trigger event
        state_next.rxAtTrig = rxFillCount >= rxTrigLevel;

        // Automatic RTS hysteresis
        if (!state_reg.feature[FEAT_AUTO_RTS]) begin
            state_next.rtsHeld = 1'b0;
        end else if (rxFillCount >= rxNextLevel) begin
            state_next.rtsHeld = 1'b1;
        end else if (rxFillCount < lowerLevel) begin
            state_next.rtsHeld = 1'b0;
        end

        // Automatic CTS: halt while the CTS pin is high
        state_next.txHalt = state_reg.feature[FEAT_AUTO_CTS] && modemIn.ctsN;

        // Sticky events, write one to clear, set wins
        state_next.evtStatus[EVT_MODEM] = anyNewFlag |
            (state_reg.evtStatus[EVT_MODEM] &
             ~(wrHit && regAddr == OFF_EVT_STATUS && regWrData[EVT_MODEM]));
        state_next.evtStatus[EVT_RX_TRIG] =
            (trigEdge && state_reg.feature[FEAT_AUTO_RTS]) |
            (state_reg.evtStatus[EVT_RX_TRIG] &
             ~(wrHit && regAddr == OFF_EVT_STATUS && regWrData[EVT_RX_TRIG]));

        // Pin drive; loop-back keeps the outputs at their inactive level
        if (loopMode) begin
            state_next.pins = '1;
        end else begin
            state_next.pins.dtrN  = ~state_reg.modemCtrl[CTRL_DTR];
            state_next.pins.out1N = ~state_reg.modemCtrl[CTRL_OUT1];
            state_next.pins.out2N = ~state_reg.modemCtrl[CTRL_OUT2];
            if (state_reg.feature[FEAT_AUTO_RTS]) begin
                state_next.pins.rtsN = state_reg.rtsHeld | ~state_reg.modemCtrl[CTRL_RTS];
            end else begin
                state_next.pins.rtsN = ~state_reg.modemCtrl[CTRL_RTS];
            end
        end

        // Read data, one cycle after the strobe
        if (regRd) begin
            unique case (regAddr)
                OFF_MODEM_CTRL: state_next.rdData = state_reg.modemCtrl;
                OFF_MODEM_STAT: state_next.rdData = statusView;
                OFF_SCRATCH:    state_next.rdData = state_reg.scratch;
                OFF_FEATURE:    state_next.rdData = featureView;
                OFF_EVT_STATUS: state_next.rdData = {6'h00, state_reg.evtStatus};
                OFF_EVT_MASK:   state_next.rdData = {6'h00, state_reg.evtMask};
                default:        state_next.rdData = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg             <= '0;
            state_reg.modemCtrl   <= RST_MODEM_CTRL;
            state_reg.scratch     <= RST_SCRATCH;
            state_reg.feature     <= RST_FEATURE;
            state_reg.changeFlags <= 4'h0;
            state_reg.evtMask     <= RST_EVT_MASK;
            state_reg.pins        <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign regRdData = state_reg.rdData;
    assign modemOut  = state_reg.pins;
    assign txHalt    = state_reg.txHalt;
    assign irq       = |(state_reg.evtStatus & state_reg.evtMask);

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_status_normal;
        @(posedge mclk) disable iff (rst)
        (regRd && regAddr == OFF_MODEM_STAT && !loopMode) |=>
            regRdData[7:4] == ~$past({modemIn.cdN, modemIn.riN, modemIn.dsrN, modemIn.ctsN});
    endproperty
    a_status_normal: assert property (p_status_normal)
        else $error("status upper bits do not mirror pins");

    property p_status_loop;
        @(posedge mclk) disable iff (rst)
        (regRd && regAddr == OFF_MODEM_STAT && loopMode) |=>
            regRdData[7:4] == $past({state_reg.modemCtrl[3:2],
                                     state_reg.modemCtrl[0], state_reg.modemCtrl[1]});
    endproperty
    a_status_loop: assert property (p_status_loop)
        else $error("loop-back status wrong");

    property p_cts_change;
        @(posedge mclk) disable iff (rst)
        (state_reg.primed && !loopMode && $changed(modemIn.ctsN) && $stable(loopMode))
            |=> state_reg.changeFlags[0];
    endproperty
    a_cts_change: assert property (p_cts_change)
        else $error("cts change not flagged");

    property p_ri_fall_no_flag;
        @(posedge mclk) disable iff (rst)
        (!loopMode && $stable(loopMode) && $fell(modemIn.riN) && !state_reg.changeFlags[2])
            |=> !state_reg.changeFlags[2];
    endproperty
    a_ri_fall_no_flag: assert property (p_ri_fall_no_flag)
        else $error("ring flag set on wrong edge");

    property p_read_clears;
        @(posedge mclk) disable iff (rst)
        (rdStatus && changeSet == 4'h0) |=> state_reg.changeFlags == 4'h0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear flags");

    property p_flag_irq;
        @(posedge mclk) disable iff (rst)
        (anyNewFlag && state_reg.evtMask[EVT_MODEM]) |=> irq;
    endproperty
    a_flag_irq: assert property (p_flag_irq)
        else $error("change flag gave no interrupt");

    property p_scratch;
        @(posedge mclk) disable iff (rst)
        (regWr && regAddr == OFF_SCRATCH) ##1 (regRd && regAddr == OFF_SCRATCH && !regWr)
            |=> regRdData == $past(regWrData, 2);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch byte lost");

    property p_auto_cts;
        @(posedge mclk) disable iff (rst)
        state_reg.feature[FEAT_AUTO_CTS] |=> txHalt == $past(modemIn.ctsN);
    endproperty
    a_auto_cts: assert property (p_auto_cts)
        else $error("transmit halt does not follow cts");

    property p_rts_hold;
        @(posedge mclk) disable iff (rst)
        (state_reg.feature[FEAT_AUTO_RTS] && rxFillCount >= rxNextLevel) |=>
            state_reg.rtsHeld ##1 (loopMode || modemOut.rtsN);
    endproperty
    a_rts_hold: assert property (p_rts_hold)
        else $error("auto rts did not raise the pin");

    property p_rts_release;
        @(posedge mclk) disable iff (rst)
        (state_reg.feature[FEAT_AUTO_RTS] && rxFillCount < lowerLevel
         && rxFillCount < rxNextLevel) |=> !state_reg.rtsHeld;
    endproperty
    a_rts_release: assert property (p_rts_release)
        else $error("auto rts did not release");

    property p_rts_plain;
        @(posedge mclk) disable iff (rst)
        (!state_reg.feature[FEAT_AUTO_RTS] && !loopMode) |=>
            modemOut.rtsN == !$past(state_reg.modemCtrl[CTRL_RTS]);
    endproperty
    a_rts_plain: assert property (p_rts_plain)
        else $error("rts does not follow control bit");

    property p_reset_pins;
        @(posedge mclk) $past(rst) |-> (modemOut.rtsN && modemOut.dtrN
                                         && state_reg.changeFlags == 4'h0);
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("reset state wrong");

    property p_dsr_change;
        @(posedge mclk) disable iff (rst)
        (state_reg.primed && !loopMode && $changed(modemIn.dsrN) && $stable(loopMode))
            |=> state_reg.changeFlags[1];
    endproperty
    a_dsr_change: assert property (p_dsr_change)
        else $error("dsr change not flagged");

    property p_cd_change;
        @(posedge mclk) disable iff (rst)
        (state_reg.primed && !loopMode && $changed(modemIn.cdN) && $stable(loopMode))
            |=> state_reg.changeFlags[3];
    endproperty
    a_cd_change: assert property (p_cd_change)
        else $error("cd change not flagged");

    property p_ri_rise_flag;
        @(posedge mclk) disable iff (rst)
        (state_reg.primed && !loopMode && $stable(loopMode) && $rose(modemIn.riN))
            |=> state_reg.changeFlags[2];
    endproperty
    a_ri_rise_flag: assert property (p_ri_rise_flag)
        else $error("ring rising edge not flagged");

    // Trigger edge must raise its event while auto RTS is on
    property p_trig_event;
        @(posedge mclk) disable iff (rst)
        (trigEdge && state_reg.feature[FEAT_AUTO_RTS]) |=> state_reg.evtStatus[EVT_RX_TRIG];
    endproperty
    a_trig_event: assert property (p_trig_event)
        else $error("trigger level gave no event");

    property p_loop_pins;
        @(posedge mclk) disable iff (rst)
        loopMode |=> modemOut == '1;
    endproperty
    a_loop_pins: assert property (p_loop_pins)
        else $error("loop-back outputs not parked");

    // Read data must not linger past its one cycle
    property p_rd_idle;
        @(posedge mclk) disable iff (rst)
        !regRd |=> regRdData == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data left standing");

    property p_reset_quiet;
        @(posedge mclk) $past(rst) |-> (!txHalt && !irq && regRdData == 8'h00);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");

    property p_reset_feature;
        @(posedge mclk) $past(rst) |-> (state_reg.feature == RST_FEATURE);
    endproperty
    a_reset_feature: assert property (p_reset_feature)
        else $error("feature enables not cleared by reset");

    c_loop_read: cover property (@(posedge mclk) disable iff (rst) rdStatus && loopMode);
    c_ri_flag: cover property (@(posedge mclk) disable iff (rst) changeSet[2]);
    c_rts_held: cover property (@(posedge mclk) disable iff (rst) $rose(state_reg.rtsHeld));
    c_tx_halt: cover property (@(posedge mclk) disable iff (rst) $rose(txHalt));
    c_trig_evt: cover property (@(posedge mclk) disable iff (rst)
                                $rose(state_reg.evtStatus[EVT_RX_TRIG]));

endmodule // modem_status_and_hw_flow

`default_nettype wire

// file: bench/modem_peer.sv
// Modem-side partner model: drives the active-low handshake pins of the block
`timescale 1ns/1ps
`default_nettype none

module modem_peer
    import modem_flow_pkg::*;
(
    input  wire logic       mclk,
    input  wire modem_in_t  pinCmd,
    input  wire logic       slowMode,
    output var  modem_in_t  modemIn = 4'hf
);
    modem_in_t stage = 4'hf;

    // Pins move just after an edge; slow mode lags one more cycle
    always @(posedge mclk) begin
        stage   <= pinCmd;
        modemIn <= slowMode ? stage : pinCmd;
    end
endmodule // modem_peer
`default_nettype wire

// file: bench/modem_status_and_hw_flow_tb.sv
// Self-checking testbench for the modem-status and hardware flow-control block
`timescale 1ns/1ps
`default_nettype none

module modem_status_and_hw_flow_tb
    import modem_flow_pkg::*;
;
    logic              mclk;
    logic              rst;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0]        regWrData;
    logic              regWr;
    logic              regRd;
    logic [7:0]        regRdData;
    modem_in_t         pinCmd;
    modem_in_t         modemIn;
    modem_out_t        modemOut;
    logic              slowMode;
    logic [5:0]        rxFillCount;
    logic [5:0]        rxTrigLevel;
    logic [5:0]        rxNextLevel;
    logic              txHalt;
    logic              irq;
    logic [7:0]        rdVal;
    int                err_total = 0;
    int                checks = 0;
    int                cycles = 0;

    modem_status_and_hw_flow #(.CNT_W(6)) dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .modemIn(modemIn), .modemOut(modemOut), .rxFillCount(rxFillCount),
        .rxTrigLevel(rxTrigLevel), .rxNextLevel(rxNextLevel), .txHalt(txHalt), .irq(irq));
    modem_peer peer (.mclk(mclk), .pinCmd(pinCmd), .slowMode(slowMode), .modemIn(modemIn));

    // ************************************************************
    // Clock, hang guard and shared tasks
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdVal = regRdData;
    endtask

    task automatic pins(input logic [3:0] p, input logic slow);
        @(posedge mclk);
        pinCmd   <= p;
        slowMode <= slow;
        tick(4);
    endtask

    // Clears leftover change flags and pending events
    task automatic flush();
        rd(OFF_MODEM_STAT);
        rd(OFF_MODEM_STAT);
        wr(OFF_EVT_STATUS, 8'h03);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk("modemOut", 8'h0f, {4'h0, modemOut});
        chk("txHalt", 8'h00, {7'h0, txHalt});
        chk("irq", 8'h00, {7'h0, irq});
        rd(OFF_MODEM_STAT);
        chk("status", 8'h90, rdVal);
        rd(OFF_SCRATCH);
        chk("scratch", RST_SCRATCH, rdVal);
        rd(OFF_FEATURE);
        chk("feature", RST_FEATURE, rdVal);
        rd(OFF_EVT_MASK);
        chk("mask", {6'h00, RST_EVT_MASK}, rdVal);
        rd(OFF_MODEM_CTRL);
        chk("ctrl", RST_MODEM_CTRL, rdVal);
    endtask

    task automatic t_scratch();
        wr(OFF_SCRATCH, 8'h5a);
        wr(3'h7, 8'h33);
        wr(OFF_MODEM_STAT, 8'h0f);
        rd(OFF_SCRATCH);
        chk("scratch", 8'h5a, rdVal);
        rd(3'h7);
        chk("unmapped", 8'h00, rdVal);
        rd(OFF_MODEM_STAT);
        chk("status", 8'h90, rdVal);
        // Write then read with no gap between the strobes
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= OFF_SCRATCH;
        regWrData <= 8'hc3;
        @(posedge mclk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdVal = regRdData;
        chk("scratchB2b", 8'hc3, rdVal);
    endtask

    // Each step moves one pin; ring falling edge must stay silent
    task automatic t_changes();
        logic [3:0] pv [6] = '{4'h7, 4'h6, 4'h4, 4'hc, 4'h8, 4'hc};
        logic [7:0] ev [6] = '{8'h81, 8'h91, 8'hb2, 8'h38, 8'h70, 8'h34};
        for (int i = 0; i < 6; i++) begin
            pins(pv[i], i[0]);
            chk("irq", {7'h0, |ev[i][3:0]}, {7'h0, irq});
            rd(OFF_MODEM_STAT);
            chk("status", ev[i], rdVal);
            rd(OFF_MODEM_STAT);
            chk("cleared", {ev[i][7:4], 4'h0}, rdVal);
            wr(OFF_EVT_STATUS, 8'h01);
            tick(1);
            chk("irq", 8'h00, {7'h0, irq});
        end
        wr(OFF_EVT_MASK, 8'h00);
        pins(4'hd, 1'b0);
        chk("masked", 8'h00, {7'h0, irq});
        rd(OFF_EVT_STATUS);
        chk("evt", 8'h01, rdVal);
        wr(OFF_EVT_MASK, 8'h03);
        tick(1);
        chk("unmasked", 8'h01, {7'h0, irq});
        pins(4'hc, 1'b0);
        flush();
    endtask

    task automatic t_loop();
        wr(OFF_MODEM_CTRL, 8'h1d);
        tick(2);
        chk("loopOut", 8'h0f, {4'h0, modemOut});
        rd(OFF_MODEM_STAT);
        chk("loopUp", 8'he0, {rdVal[7:4], 4'h0});
        wr(OFF_MODEM_CTRL, 8'h12);
        tick(2);
        rd(OFF_MODEM_STAT);
        chk("loopFlip", 8'h1f, rdVal);
        wr(OFF_MODEM_CTRL, 8'h00);
        tick(2);
        flush();
        rd(OFF_MODEM_STAT);
        chk("pinsBack", 8'h30, rdVal);
    endtask

    task automatic t_cts();
        wr(OFF_FEATURE, 8'h80);
        pins(4'hd, 1'b0);
        chk("halt", 8'h01, {7'h0, txHalt});
        pins(4'hc, 1'b1);
        chk("resume", 8'h00, {7'h0, txHalt});
        wr(OFF_FEATURE, 8'h00);
        pins(4'hd, 1'b0);
        chk("noAuto", 8'h00, {7'h0, txHalt});
        pins(4'hc, 1'b0);
        flush();
    endtask

    // Trigger at 4, hold at 8, release below 3
    task automatic t_rts();
        wr(OFF_MODEM_CTRL, 8'h0f);
        tick(2);
        chk("allOn", 8'h00, {4'h0, modemOut});
        rd(OFF_MODEM_CTRL);
        chk("ctrl", 8'h0f, rdVal);
        wr(OFF_MODEM_CTRL, 8'h02);
        tick(2);
        chk("rtsOn", 8'h0d, {4'h0, modemOut});
        wr(OFF_FEATURE, 8'h40);
        wr(OFF_EVT_STATUS, 8'h03);
        @(posedge mclk) rxFillCount <= 6'h04;
        tick(3);
        chk("atTrig", 8'h0d, {4'h0, modemOut});
        rd(OFF_EVT_STATUS);
        chk("trigEvt", 8'h02, rdVal);
        @(posedge mclk) rxFillCount <= 6'h08;
        tick(3);
        chk("held", 8'h0f, {4'h0, modemOut});
        rd(OFF_FEATURE);
        chk("featHeld", 8'h00, rdVal);
        @(posedge mclk) rxFillCount <= 6'h03;
        tick(3);
        chk("stillHeld", 8'h0f, {4'h0, modemOut});
        @(posedge mclk) rxFillCount <= 6'h02;
        tick(3);
        chk("released", 8'h0d, {4'h0, modemOut});
        rd(OFF_FEATURE);
        chk("featFree", 8'h40, rdVal);
    endtask

    // Reset in mid-run with a flag pending and registers away from defaults
    task automatic t_rerst();
        pins(4'hd, 1'b0);
        wr(OFF_SCRATCH, 8'h3c);
        @(posedge mclk) rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk("rstPins", 8'h0f, {4'h0, modemOut});
        chk("rstIrq", 8'h00, {7'h0, irq});
        chk("rstHalt", 8'h00, {7'h0, txHalt});
        rd(OFF_MODEM_STAT);
        chk("rstStatus", 8'h20, rdVal);
        rd(OFF_SCRATCH);
        chk("rstScratch", RST_SCRATCH, rdVal);
        rd(OFF_FEATURE);
        chk("rstFeature", RST_FEATURE, rdVal);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        regAddr = '0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        pinCmd = 4'h6;
        slowMode = 1'b0;
        rxFillCount = 6'h00;
        rxTrigLevel = 6'h04;
        rxNextLevel = 6'h08;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        tick(2);
        t_reset();
        t_scratch();
        t_changes();
        t_loop();
        t_cts();
        t_rts();
        t_rerst();
        complete_run();
    end
endmodule // modem_status_and_hw_flow_tb
`default_nettype wire
